// ==== common/reset_bank_pkg.sv ====
// Shared constants and types for the reset source and bank select block
package reset_bank_pkg;

    // ==================================================================
    // Timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam longint unsigned BOOT_TIMEOUT_MS = 400;
    localparam longint unsigned BOOT_TIMEOUT_CYCLES = BOOT_TIMEOUT_MS * CLK_HZ / 1000;
    localparam int unsigned BO_FILTER_CYCLES = 4;
    localparam int unsigned RESET_HOLD_CYCLES = 4;

    // ==================================================================
    // Register map
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] OFS_POWER_CONTROL = 8'h00;
    localparam logic [7:0] OFS_FLASH_CONFIG = 8'h01;
    localparam logic [7:0] OFS_AUX_IRQ_ENABLE = 8'h02;
    localparam logic [7:0] OFS_WATCHDOG_CONTROL = 8'h03;
    localparam logic [7:0] OFS_BOOT_CONTROL = 8'h04;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h05;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h06;

    // ==================================================================
    // Field positions
    localparam int POWER_UP_BIT = 4;
    localparam int SOFT_BANK_BIT = 1;
    localparam int BOOT_SEL_BIT = 0;
    localparam int BO_IRQ_EN_BIT = 3;
    localparam int WDFLAG_BIT = 2;
    localparam int EMUL_BIT = 0;
    localparam int PROG_RD_BIT = 1;
    localparam int EMUL_RD_BIT = 2;

    // Event bits of the status and mask registers
    localparam int NUM_EVENTS = 5;
    localparam int EV_POWER_ON = 0;
    localparam int EV_SOFT = 1;
    localparam int EV_BROWNOUT_RST = 2;
    localparam int EV_WATCHDOG = 3;
    localparam int EV_BROWNOUT_IRQ = 4;

    // ==================================================================
    // Bank values and code addresses
    localparam logic [1:0] BANK_BOOT = 2'h0;
    localparam logic [1:0] BANK_USER = 2'h2;
    localparam logic [15:0] BOOT_AREA_TOP = 16'h1fff;
    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [15:0] VEC_BROWNOUT = 16'h004b;

    // ==================================================================
    // Types
    typedef enum logic [1:0] {
        BOOT_AUTOBAUD = 2'h0,
        BOOT_PROGRAM = 2'h1,
        BOOT_EMUL = 2'h3,
        BOOT_USER = 2'h2
    } boot_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage : reset_bank_pkg

// ==== hw/reset_source_bank_select.sv ====
// Reset source handling, brownout filter and code bank selection
// Function
// R1: Power-up flag set, held until software clears
// R2: Power-on reset forces bank bits to 00
// R3: Autobaud window, then emulation or software reset
// R4: External reset pin acts as power-on reset; code keeps the emulation flag and brownout count
// R5: Soft-reset bit rising 0 to 1 triggers reset
// R6: Software reset: vector 0000H, bank bits 10
// R7: Software reset keeps watchdog flag, resets others; code also keeps the power-up and emulation flags
// R8: Brownout acts after four low clock periods
// R9: Brownout without interrupt enable resets to 0000H
// R10: Enabled brownout raises interrupt to 004BH
// R11: Clearing enable during brownout resets the device
// R12: Brownout reset clears boot-select, keeps soft-reset bit
// R13: Watchdog reset clears boot-select, keeps soft-reset bit
// R14: Low 8 kB from boot code when bits 00
// R15: Brownout resets by default
// R16: Power-on or external reset wins over others
`timescale 1ns/100ps
`default_nettype none

module reset_source_bank_select #(
    parameter longint unsigned BOOT_TIMEOUT = reset_bank_pkg::BOOT_TIMEOUT_CYCLES,
    parameter int unsigned BO_FILTER = reset_bank_pkg::BO_FILTER_CYCLES,
    parameter int unsigned RESET_HOLD = reset_bank_pkg::RESET_HOLD_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ext_reset_n,
    input wire logic supply_low,
    input wire logic watchdog_expired,
    input wire logic autobaud_ok,
    input wire logic [15:0] fetch_addr,
    input wire reset_bank_pkg::reg_req_t reg_req,
    output logic [reset_bank_pkg::DATA_W-1:0] reg_rdata,
    output logic core_reset,
    output logic [15:0] core_vector,
    output logic brownout_irq_req,
    output logic emulation_mode,
    output logic program_mode,
    output logic fetch_from_boot,
    output logic [1:0] bank_bits,
    output logic irq
);

    // ==================================================================
    // State
    typedef struct packed {
        reset_bank_pkg::boot_state_t boot_state;
        logic [31:0] boot_timer;
        logic [7:0] bo_count;
        logic bo_active;
        logic [7:0] hold_count;
        logic core_reset;
        logic [15:0] vector;
        logic bo_irq_req;
        logic power_up_flag;
        logic [1:0] bank;
        logic bo_irq_en;
        logic wd_flag;
        logic emul_flag;
        logic [reset_bank_pkg::NUM_EVENTS-1:0] status;
        logic [reset_bank_pkg::NUM_EVENTS-1:0] mask;
        logic irq;
        logic [reset_bank_pkg::DATA_W-1:0] rdata;
        logic fetch_boot;
        logic emul_mode;
        logic prog_mode;
    } state_t;

    localparam state_t STATE_RESET = '{
        boot_state: reset_bank_pkg::BOOT_AUTOBAUD,
        hold_count: RESET_HOLD[7:0],
        core_reset: 1'b1,
        vector: reset_bank_pkg::VEC_RESET,
        power_up_flag: 1'b1,
        bank: reset_bank_pkg::BANK_BOOT,
        status: reset_bank_pkg::NUM_EVENTS'(1 << reset_bank_pkg::EV_POWER_ON),
        default: '0
    };

    localparam logic [31:0] BOOT_LAST = 32'(BOOT_TIMEOUT - 1);
    localparam logic [7:0] BO_LAST = 8'(BO_FILTER);

    state_t state_reg;
    state_t state_next;

    // ==================================================================
    // Next-state logic
    always_comb
    begin
        logic ext_rst;
        logic sw_evt;
        logic boot_sw;
        logic bo_rst;
        logic wd_evt;
        logic any_rst;
        logic [reset_bank_pkg::NUM_EVENTS-1:0] ev;
        logic [reset_bank_pkg::NUM_EVENTS-1:0] clr;
        ext_rst = 1'b0;
        sw_evt = 1'b0;
        boot_sw = 1'b0;
        bo_rst = 1'b0;
        wd_evt = 1'b0;
        any_rst = 1'b0;
        ev = '0;
        clr = '0;
        state_next = state_reg;
        state_next.bo_irq_req = 1'b0;
        state_next.rdata = '0;

        // ==============================================================
        // Brownout filter: supply must stay low for the full count
        if (supply_low)
        begin
            if (state_reg.bo_count < BO_LAST)
            begin
                state_next.bo_count = state_reg.bo_count + 8'h01; // R8
            end
        end
        else
        begin
            state_next.bo_count = '0;
        end
        state_next.bo_active = (state_next.bo_count >= BO_LAST); // R8
        if (state_next.bo_active && !state_reg.bo_active && state_reg.bo_irq_en)
        begin
            state_next.bo_irq_req = 1'b1; // R10
            ev[reset_bank_pkg::EV_BROWNOUT_IRQ] = 1'b1;
        end

        // ==============================================================
        // Register writes
        if (reg_req.wr)
        begin
            case (reg_req.addr)
                reset_bank_pkg::OFS_POWER_CONTROL:
                begin
                    state_next.power_up_flag = state_reg.power_up_flag
                        && reg_req.wdata[reset_bank_pkg::POWER_UP_BIT]; // R1
                end
                reset_bank_pkg::OFS_FLASH_CONFIG:
                begin
                    if (!state_reg.bank[1] && reg_req.wdata[reset_bank_pkg::SOFT_BANK_BIT])
                    begin
                        sw_evt = 1'b1; // R5
                    end
                    else
                    begin
                        state_next.bank = {reg_req.wdata[reset_bank_pkg::SOFT_BANK_BIT],
                            reg_req.wdata[reset_bank_pkg::BOOT_SEL_BIT]};
                    end
                end
                reset_bank_pkg::OFS_AUX_IRQ_ENABLE:
                begin
                    state_next.bo_irq_en = reg_req.wdata[reset_bank_pkg::BO_IRQ_EN_BIT];
                end
                reset_bank_pkg::OFS_WATCHDOG_CONTROL:
                begin
                    state_next.wd_flag = state_reg.wd_flag
                        && reg_req.wdata[reset_bank_pkg::WDFLAG_BIT];
                end
                reset_bank_pkg::OFS_BOOT_CONTROL:
                begin
                    state_next.emul_flag = reg_req.wdata[reset_bank_pkg::EMUL_BIT];
                end
                reset_bank_pkg::OFS_IRQ_STATUS:
                begin
                    clr = reg_req.wdata[reset_bank_pkg::NUM_EVENTS-1:0];
                end
                reset_bank_pkg::OFS_IRQ_MASK:
                begin
                    state_next.mask = reg_req.wdata[reset_bank_pkg::NUM_EVENTS-1:0];
                end
                default:
                begin
                    state_next.mask = state_reg.mask;
                end
            endcase
        end

        // ==============================================================
        // Register reads, data in the following cycle
        if (reg_req.rd)
        begin
            case (reg_req.addr)
                reset_bank_pkg::OFS_POWER_CONTROL:
                begin
                    state_next.rdata[reset_bank_pkg::POWER_UP_BIT] = state_reg.power_up_flag;
                end
                reset_bank_pkg::OFS_FLASH_CONFIG:
                begin
                    state_next.rdata[reset_bank_pkg::SOFT_BANK_BIT] = state_reg.bank[1];
                    state_next.rdata[reset_bank_pkg::BOOT_SEL_BIT] = state_reg.bank[0];
                end
                reset_bank_pkg::OFS_AUX_IRQ_ENABLE:
                begin
                    state_next.rdata[reset_bank_pkg::BO_IRQ_EN_BIT] = state_reg.bo_irq_en;
                end
                reset_bank_pkg::OFS_WATCHDOG_CONTROL:
                begin
                    state_next.rdata[reset_bank_pkg::WDFLAG_BIT] = state_reg.wd_flag;
                end
                reset_bank_pkg::OFS_BOOT_CONTROL:
                begin
                    state_next.rdata[reset_bank_pkg::EMUL_BIT] = state_reg.emul_flag;
                    state_next.rdata[reset_bank_pkg::PROG_RD_BIT] =
                        (state_reg.boot_state == reset_bank_pkg::BOOT_PROGRAM);
                    state_next.rdata[reset_bank_pkg::EMUL_RD_BIT] =
                        (state_reg.boot_state == reset_bank_pkg::BOOT_EMUL);
                end
                reset_bank_pkg::OFS_IRQ_STATUS:
                begin
                    state_next.rdata[reset_bank_pkg::NUM_EVENTS-1:0] = state_reg.status;
                end
                reset_bank_pkg::OFS_IRQ_MASK:
                begin
                    state_next.rdata[reset_bank_pkg::NUM_EVENTS-1:0] = state_reg.mask;
                end
                default:
                begin
                    state_next.rdata = '0;
                end
            endcase
        end

        // ==============================================================
        // Boot supervisor: autobaud window after power-on
        case (state_reg.boot_state)
            reset_bank_pkg::BOOT_AUTOBAUD:
            begin
                if (state_reg.core_reset)
                begin
                    state_next.boot_timer = '0;
                end
                else if (autobaud_ok)
                begin
                    state_next.boot_state = reset_bank_pkg::BOOT_PROGRAM; // R3
                end
                else if (state_reg.boot_timer >= BOOT_LAST)
                begin
                    if (state_reg.emul_flag)
                    begin
                        state_next.boot_state = reset_bank_pkg::BOOT_EMUL; // R3
                    end
                    else
                    begin
                        boot_sw = 1'b1; // R3
                    end
                end
                else
                begin
                    state_next.boot_timer = state_reg.boot_timer + 32'h1;
                end
            end
            reset_bank_pkg::BOOT_PROGRAM,
            reset_bank_pkg::BOOT_EMUL,
            reset_bank_pkg::BOOT_USER:
            begin
                state_next.boot_timer = '0;
            end
            default:
            begin
                state_next.boot_state = reset_bank_pkg::BOOT_AUTOBAUD;
            end
        endcase

        // ==============================================================
        // Reset sources, highest priority last applied first
        ext_rst = !ext_reset_n;
        wd_evt = watchdog_expired;
        bo_rst = state_next.bo_active && !state_next.bo_irq_en; // R9 R11 R15
        any_rst = ext_rst || sw_evt || boot_sw || bo_rst || wd_evt;
        if (ext_rst)
        begin
            state_next = STATE_RESET; // R4 R16
            state_next.bo_count = state_reg.bo_count;
            state_next.emul_flag = state_reg.emul_flag;
            ev[reset_bank_pkg::EV_POWER_ON] = 1'b1;
        end
        else if (any_rst)
        begin
            if (sw_evt || boot_sw)
            begin
                state_next.bank = reset_bank_pkg::BANK_USER; // R6
                ev[reset_bank_pkg::EV_SOFT] = 1'b1;
            end
            else
            begin
                state_next.bank[0] = 1'b0; // R12 R13
            end
            if (bo_rst)
            begin
                ev[reset_bank_pkg::EV_BROWNOUT_RST] = 1'b1;
            end
            if (wd_evt)
            begin
                state_next.wd_flag = 1'b1;
                ev[reset_bank_pkg::EV_WATCHDOG] = 1'b1;
            end
            // Brownout interrupt enable and event mask return to reset; watchdog, power-up and emulation flags kept
            state_next.bo_irq_en = 1'b0; // R7
            state_next.mask = '0; // R7
            state_next.bo_irq_req = 1'b0;
            state_next.boot_timer = '0;
            state_next.boot_state = (state_next.bank == reset_bank_pkg::BANK_BOOT) ?
                reset_bank_pkg::BOOT_AUTOBAUD : reset_bank_pkg::BOOT_USER;
        end

        // ==============================================================
        // Core reset stretch and restart vector
        if (any_rst)
        begin
            state_next.hold_count = RESET_HOLD[7:0];
            state_next.core_reset = 1'b1;
            state_next.vector = reset_bank_pkg::VEC_RESET; // R6 R9
        end
        else
        begin
            if (state_reg.hold_count != '0)
            begin
                state_next.hold_count = state_reg.hold_count - 8'h01;
            end
            state_next.core_reset = (state_reg.hold_count > 8'h01);
            if (state_next.bo_irq_req)
            begin
                state_next.vector = reset_bank_pkg::VEC_BROWNOUT; // R10
            end
        end

        // ==============================================================
        // Interrupt status: set wins over a clear in the same cycle
        state_next.status = (state_reg.status & ~clr) | ev;
        state_next.irq = |(state_next.status & state_next.mask);

        // Code fetch steering for the lower 8 kB
        state_next.fetch_boot = (fetch_addr <= reset_bank_pkg::BOOT_AREA_TOP)
            && (state_next.bank == reset_bank_pkg::BANK_BOOT); // R14

        // Mode outputs get flops of their own
        state_next.emul_mode = (state_next.boot_state == reset_bank_pkg::BOOT_EMUL); // R3
        state_next.prog_mode = (state_next.boot_state == reset_bank_pkg::BOOT_PROGRAM); // R3
    end

    // ==================================================================
    // State register; power-on is the asynchronous reset
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= STATE_RESET; // R1 R2
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ==================================================================
    // Outputs
    assign reg_rdata = state_reg.rdata;
    assign core_reset = state_reg.core_reset;
    assign core_vector = state_reg.vector;
    assign brownout_irq_req = state_reg.bo_irq_req;
    assign emulation_mode = state_reg.emul_mode;
    assign program_mode = state_reg.prog_mode;
    assign fetch_from_boot = state_reg.fetch_boot;
    assign bank_bits = state_reg.bank;
    assign irq = state_reg.irq;

endmodule : reset_source_bank_select

`default_nettype wire

// ==== testbench/far_side_model.sv ====
// Far side model: supply monitor, reset pin, watchdog and boot host
`timescale 1ns/100ps
`default_nettype none

module far_side_model (
    input wire logic core_clk,
    output var logic ext_reset_n,
    output var logic supply_low,
    output var logic watchdog_expired,
    output var logic autobaud_ok,
    output var logic [15:0] fetch_addr
);
    initial
    begin
        ext_reset_n = 1'b1;
        supply_low = 1'b0;
        watchdog_expired = 1'b0;
        autobaud_ok = 1'b0;
        fetch_addr = 16'h0000;
    end

    // Supply below threshold for n sampled cycles
    task automatic sag(input int n);
        repeat (n) @(posedge core_clk) supply_low <= 1'b1;
        @(posedge core_clk) supply_low <= 1'b0;
    endtask : sag

    // One cycle of pin reset, optionally with a watchdog event beside it
    task automatic pin_reset(input logic dog);
        @(posedge core_clk);
        ext_reset_n <= 1'b0;
        watchdog_expired <= dog;
        @(posedge core_clk);
        ext_reset_n <= 1'b1;
        watchdog_expired <= 1'b0;
    endtask : pin_reset

    task automatic dog();
        @(posedge core_clk) watchdog_expired <= 1'b1;
        @(posedge core_clk) watchdog_expired <= 1'b0;
    endtask : dog

    task automatic host(input logic ok);
        @(posedge core_clk) autobaud_ok <= ok;
    endtask : host

    task automatic fetch(input logic [15:0] a);
        @(posedge core_clk) fetch_addr <= a;
        @(posedge core_clk);
    endtask : fetch
endmodule : far_side_model

`default_nettype wire

// ==== testbench/reset_bank_props.sv ====
// Port-level checks for the reset source and bank select block
`timescale 1ns/100ps
`default_nettype none

module reset_bank_props #(
    parameter longint unsigned BOOT_TIMEOUT = 20,
    parameter int unsigned BO_FILTER = 4,
    parameter int unsigned RESET_HOLD = 4
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ext_reset_n,
    input wire logic supply_low,
    input wire logic watchdog_expired,
    input wire logic autobaud_ok,
    input wire logic [15:0] fetch_addr,
    input wire reset_bank_pkg::reg_req_t reg_req,
    input wire logic [reset_bank_pkg::DATA_W-1:0] reg_rdata,
    input wire logic core_reset,
    input wire logic [15:0] core_vector,
    input wire logic brownout_irq_req,
    input wire logic emulation_mode,
    input wire logic program_mode,
    input wire logic fetch_from_boot,
    input wire logic [1:0] bank_bits,
    input wire logic irq
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // ==================================================================
    // Sequences
    sequence bo_onset;
        !supply_low ##1 supply_low [*4];
    endsequence
    sequence soft_req;
        reg_req.wr && reg_req.addr == reset_bank_pkg::OFS_FLASH_CONFIG && reg_req.wdata[1]
            && !bank_bits[1] && ext_reset_n && !watchdog_expired && !supply_low;
    endsequence
    sequence user_reset;
        core_reset && bank_bits == reset_bank_pkg::BANK_USER
            && core_vector == reset_bank_pkg::VEC_RESET;
    endsequence

    // ==================================================================
    // Assertions
    bo_filter_a: assert property ($rose(brownout_irq_req) |->
        $past(supply_low, 1) && $past(supply_low, 2) && $past(supply_low, 3)
        && $past(supply_low, 4)) else $error("brownout acted before the filter ran out");
    bo_response_a: assert property (bo_onset |=>
        (core_reset && !bank_bits[0] && core_vector == reset_bank_pkg::VEC_RESET)
        || (brownout_irq_req && core_vector == reset_bank_pkg::VEC_BROWNOUT))
        else $error("brownout gave neither reset nor interrupt");
    soft_reset_a: assert property (soft_req |=> user_reset)
        else $error("soft reset did not give user bank and vector zero");
    no_spurious_a: assert property (reg_req.wr && bank_bits[1] && !core_reset
        && reg_req.addr == reset_bank_pkg::OFS_FLASH_CONFIG && ext_reset_n
        && !watchdog_expired && !supply_low |=> !core_reset)
        else $error("reset without a 0 to 1 change of the soft bit");
    ext_reset_a: assert property (!ext_reset_n |=> core_reset
        && bank_bits == reset_bank_pkg::BANK_BOOT && core_vector == reset_bank_pkg::VEC_RESET)
        else $error("pin reset did not give boot bank");
    watchdog_a: assert property (watchdog_expired && ext_reset_n && !reg_req.wr |=>
        core_reset && !bank_bits[0] && bank_bits[1] == $past(bank_bits[1]))
        else $error("watchdog reset changed the wrong bank bit");
    vector_irq_a: assert property ($rose(brownout_irq_req) |->
        core_vector == reset_bank_pkg::VEC_BROWNOUT ##1 !brownout_irq_req)
        else $error("brownout interrupt vector or pulse wrong");
    fetch_map_a: assert property (rst_n |=> fetch_from_boot ==
        ($past(fetch_addr <= reset_bank_pkg::BOOT_AREA_TOP) && bank_bits == 2'h0))
        else $error("fetch routed to the wrong code block");
    mode_excl_a: assert property (!(program_mode && emulation_mode))
        else $error("programming and emulation modes at once");
endmodule : reset_bank_props

bind reset_source_bank_select reset_bank_props #(
    .BOOT_TIMEOUT(BOOT_TIMEOUT), .BO_FILTER(BO_FILTER), .RESET_HOLD(RESET_HOLD)
) i_props (
    .core_clk(core_clk), .rst_n(rst_n), .ext_reset_n(ext_reset_n),
    .supply_low(supply_low), .watchdog_expired(watchdog_expired),
    .autobaud_ok(autobaud_ok), .fetch_addr(fetch_addr), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .core_reset(core_reset), .core_vector(core_vector),
    .brownout_irq_req(brownout_irq_req), .emulation_mode(emulation_mode),
    .program_mode(program_mode), .fetch_from_boot(fetch_from_boot),
    .bank_bits(bank_bits), .irq(irq)
);

`default_nettype wire

// ==== testbench/reset_source_bank_select_tb_top.sv ====
// Self-checking bench for the reset source and bank select block
`timescale 1ns/100ps
`default_nettype none

module reset_source_bank_select_tb_top;
    logic core_clk, rst_n, ext_reset_n, supply_low, watchdog_expired, autobaud_ok;
    logic [15:0] fetch_addr, core_vector;
    reset_bank_pkg::reg_req_t reg_req;
    logic [7:0] reg_rdata;
    logic core_reset, brownout_irq_req, emulation_mode, program_mode, fetch_from_boot, irq;
    logic [1:0] bank_bits;
    int n_fail = 0;
    int n_compared = 0;
    int cycles = 0;

    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    far_side_model i_far (.core_clk(core_clk), .ext_reset_n(ext_reset_n),
        .supply_low(supply_low), .watchdog_expired(watchdog_expired),
        .autobaud_ok(autobaud_ok), .fetch_addr(fetch_addr));

    reset_source_bank_select #(.BOOT_TIMEOUT(20)) i_dut (.core_clk(core_clk), .rst_n(rst_n),
        .ext_reset_n(ext_reset_n), .supply_low(supply_low),
        .watchdog_expired(watchdog_expired), .autobaud_ok(autobaud_ok),
        .fetch_addr(fetch_addr), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .core_reset(core_reset), .core_vector(core_vector),
        .brownout_irq_req(brownout_irq_req), .emulation_mode(emulation_mode),
        .program_mode(program_mode), .fetch_from_boot(fetch_from_boot),
        .bank_bits(bank_bits), .irq(irq));

    // ==================================================================
    // Tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        n_compared++;
        if (seen !== want)
        begin
            n_fail++;
            $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, want);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk) reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk) reg_req.wr <= 1'b0;
        @(negedge core_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk) reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk) reg_req.rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask : rd

    task automatic idle();
        for (int i = 0; i < 20 && core_reset !== 1'b0; i++)
            @(negedge core_clk);
    endtask : idle

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_fail++;
            end_sim();
        end
    end

    // ==================================================================
    // Tests
    initial
    begin
        logic [7:0] d;
        int k;
        rst_n = 1'b0;
        reg_req = '0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        chk(bank_bits, reset_bank_pkg::BANK_BOOT);
        chk(core_vector, reset_bank_pkg::VEC_RESET);
        rd(8'h00, d);
        chk(d[4], 1'b1);
        // No host answer and no emulation flag: boot code soft-resets into user code
        for (k = 0; k < 60 && bank_bits !== 2'h2; k++) @(negedge core_clk);
        chk(bank_bits, reset_bank_pkg::BANK_USER);
        chk(emulation_mode, 1'b0);
        idle();
        wr(8'h04, 8'h01);
        wr(8'h00, 8'h00);
        rd(8'h00, d);
        chk(d[4], 1'b0);
        i_far.pin_reset(1'b0);
        @(negedge core_clk);
        chk(bank_bits, reset_bank_pkg::BANK_BOOT);
        chk(core_reset, 1'b1);
        for (k = 0; k < 60 && emulation_mode !== 1'b1; k++) @(negedge core_clk);
        chk(emulation_mode, 1'b1);
        rd(8'h00, d);
        chk(d[4], 1'b1);
        // Pin reset and watchdog together: pin values win
        i_far.host(1'b1);
        i_far.pin_reset(1'b1);
        @(negedge core_clk);
        chk(bank_bits, reset_bank_pkg::BANK_BOOT);
        for (k = 0; k < 60 && program_mode !== 1'b1; k++) @(negedge core_clk);
        chk(program_mode, 1'b1);
        i_far.fetch(16'h1fff);
        @(negedge core_clk);
        chk(fetch_from_boot, 1'b1);
        i_far.fetch(16'h2000);
        @(negedge core_clk);
        chk(fetch_from_boot, 1'b0);
        idle();
        wr(8'h06, 8'h01);
        chk(irq, 1'b1);
        wr(8'h05, 8'h01);
        chk(irq, 1'b0);
        wr(8'h02, 8'h08);
        wr(8'h01, 8'h02);
        chk(bank_bits, reset_bank_pkg::BANK_USER);
        chk(core_reset, 1'b1);
        chk(core_vector, reset_bank_pkg::VEC_RESET);
        idle();
        rd(8'h02, d);
        chk(d[3], 1'b0);
        wr(8'h01, 8'h03);
        chk(core_reset, 1'b0);
        i_far.dog();
        @(negedge core_clk);
        chk(bank_bits, reset_bank_pkg::BANK_USER);
        idle();
        wr(8'h01, 8'h00);
        wr(8'h01, 8'h02);
        idle();
        rd(8'h03, d);
        chk(d[2], 1'b1);
        // Brownout shorter than the filter, then just long enough
        wr(8'h01, 8'h03);
        i_far.sag(3);
        @(negedge core_clk);
        chk(core_reset, 1'b0);
        i_far.sag(4);
        @(negedge core_clk);
        chk(core_reset, 1'b1);
        chk(bank_bits, reset_bank_pkg::BANK_USER);
        chk(core_vector, reset_bank_pkg::VEC_RESET);
        idle();
        wr(8'h06, 8'h04);
        chk(irq, 1'b1);
        wr(8'h05, 8'h04);
        chk(irq, 1'b0);
        wr(8'h02, 8'h08);
        fork
            i_far.sag(12);
            begin
                for (k = 0; k < 10 && brownout_irq_req !== 1'b1; k++) @(negedge core_clk);
                chk(brownout_irq_req, 1'b1);
                chk(core_vector, reset_bank_pkg::VEC_BROWNOUT);
                chk(core_reset, 1'b0);
                wr(8'h02, 8'h00);
                chk(core_reset, 1'b1);
            end
        join
        idle();
        rd(8'h07, d);
        chk(d, 8'h00);
        end_sim();
    end
endmodule : reset_source_bank_select_tb_top

`default_nettype wire
